// *** sfs_pkg.sv ***
// sfs_pkg: constants and types of the serial ferroelectric memory slave
// assumes: shared by the top, its memory carrier and its array
package sfs_pkg;

  localparam int SFS_ADDR_W    = 13;
  localparam int SFS_MEM_DEPTH = 8192;
  localparam int SFS_TGL_W     = 3;

  // opcode values are arbitrary defaults, not taken from any part
  localparam logic [7:0] SFS_OP_WREN = 8'h06;
  localparam logic [7:0] SFS_OP_WRDI = 8'h04;
  localparam logic [7:0] SFS_OP_RDSR = 8'h05;
  localparam logic [7:0] SFS_OP_WRSR = 8'h01;
  localparam logic [7:0] SFS_OP_READ = 8'h03;
  localparam logic [7:0] SFS_OP_WRIT = 8'h02;

  localparam int SFS_ST_LOCK  = 7;
  localparam int SFS_ST_BP_HI = 3;
  localparam int SFS_ST_BP_LO = 2;
  localparam int SFS_ST_WEL   = 1;

  localparam logic [7:0] SFS_ST_WR_MASK = 8'h8C;
  localparam logic [7:0] SFS_STATUS_RST = 8'h00;

  localparam logic [1:0] SFS_BP_QUARTER = 2'h1;
  localparam logic [1:0] SFS_BP_HALF    = 2'h2;
  localparam logic [1:0] SFS_BP_ALL     = 2'h3;

  localparam logic [12:0] SFS_QUARTER_BASE = 13'h1800;
  localparam logic [12:0] SFS_HALF_BASE    = 13'h1000;
  localparam logic [12:0] SFS_ADDR_ONE     = 13'h0001;

  localparam logic [2:0] SFS_BIT_LAST = 3'h7;
  localparam logic [2:0] SFS_BIT_ONE  = 3'h1;

  typedef enum logic [2:0]
  {
    SFS_PH_OPCODE,
    SFS_PH_ADDR_HI,
    SFS_PH_ADDR_LO,
    SFS_PH_DATA_WR,
    SFS_PH_DATA_RD,
    SFS_PH_STAT_WR,
    SFS_PH_STAT_RD,
    SFS_PH_IGNORE
  } sfs_phase_e;

endpackage

// *** sfs_mem_if.sv ***
// sfs_mem_if: write and read lines between the link logic and the array
// assumes: both ends sit on the serial clock domain
`timescale 1ns/1ps
interface sfs_mem_if;
  import sfs_pkg::*;

  logic                  wr_en;
  logic [SFS_ADDR_W-1:0] wr_addr;
  logic [7:0]            wr_data;
  logic [SFS_ADDR_W-1:0] rd_addr;
  logic [7:0]            rd_data;

  modport ctrl
  (
    output wr_en,
    output wr_addr,
    output wr_data,
    output rd_addr,
    input  rd_data
  );

  modport array
  (
    input  wr_en,
    input  wr_addr,
    input  wr_data,
    input  rd_addr,
    output rd_data
  );

endinterface

// *** sfs_sync.sv ***
// sfs_sync: two flip-flop level synchroniser, one bit per lane
// assumes: each lane is a level or a toggle, never a multi-bit word
`timescale 1ns/1ps
module sfs_sync
#(
  parameter int W = 1
)
(
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// *** sfs_mem.sv ***
// sfs_mem: byte array held in flip-flops, written on the serial clock
// assumes: write strobe already qualified by select and hold
`timescale 1ns/1ps
module sfs_mem
  import sfs_pkg::*;
(
  input  wire logic clk,
  sfs_mem_if.array  mem
);

  // contents survive reset, like the nonvolatile cells they stand for
  logic [7:0] cell_reg [SFS_MEM_DEPTH];

  always_ff @(posedge clk)
  begin
    if (mem.wr_en)
    begin
      cell_reg[mem.wr_addr] <= mem.wr_data; // RULE_11
    end
  end

  assign mem.rd_data = cell_reg[mem.rd_addr];

endmodule

// *** sfs_top.sv ***
// sfs_top: serial peripheral slave of a byte memory with protection
// assumes: sck comes from the bus master; clk_sys is a free system clock
`timescale 1ns/1ps

// Contract
// RULE_01: chip select high means standby, inputs ignored, output tristated.
// RULE_02: every opcode starts after a fresh chip select fall; decode restarts there.
// RULE_03: input sampled on rising clock edges only; output changes on falling edges.
// RULE_04: any clock rate up to 20 MHz, clock may stop anywhere.
// RULE_05: output driven only while returning read data, never while hold low.
// RULE_06: status write refused when lock bit is one and protect pin low.
// RULE_07: hold low suspends the transfer and ignores clock and select.
// RULE_08: master changes hold only while the serial clock is low.
// RULE_09: clock edges count only while chip select is low.
// RULE_10: array holds 8192 locations of eight bits.
// RULE_11: each byte is written on its eighth bit, no busy time.
// RULE_12: both clock modes zero and three are supported.
// RULE_13: upper quarter, upper half or whole array can be write protected.
// RULE_14: write disable opcode blocks writes until enabled again.
// RULE_15: first byte after select is the opcode, then address and data.
// RULE_16: two address bytes, top three bits ignored, thirteen bits used.
// RULE_17: unknown opcode ignored with all input until next select fall.
// RULE_18: clock low at select fall means mode zero, high means mode three.
// RULE_19: write enable latch must be set before any array or status write.
module sfs_top
  import sfs_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic si,
  output logic      so,
  output logic      so_oe,
  input  wire logic wp_n,
  input  wire logic hold_n,
  output logic      standby,
  output logic      spi_mode3,
  output logic      byte_commit,
  output logic      write_refused,
  output logic      bad_opcode
);

  sfs_mem_if mem_bus ();

  // link side, clocked by sck
  logic                  frame_rst_n;
  logic                  link_go;
  logic [2:0]            bit_cnt_reg;
  logic [6:0]            shift_reg;
  logic [7:0]            byte_in;
  logic                  byte_done;
  sfs_phase_e            phase_reg;
  logic                  op_read_reg;
  logic [SFS_ADDR_W-1:0] addr_reg;
  logic [7:0]            tx_reg;
  logic                  so_reg;
  logic                  drive_reg;
  logic [7:0]            status_reg;
  logic                  wel_reg;
  logic [7:0]            status_view;
  logic                  array_locked;
  logic                  status_locked;
  logic [SFS_TGL_W-1:0]  tgl_reg;
  logic [SFS_TGL_W-1:0]  tgl_next;
  logic                  mode_lnk_reg;

  // system side
  logic [SFS_TGL_W+1:0]  sync_in;
  logic [SFS_TGL_W+1:0]  sync_q;
  logic                  cs_prev_reg;
  logic [SFS_TGL_W-1:0]  tgl_prev_reg;
  logic                  standby_reg;
  logic                  mode3_reg;
  logic [SFS_TGL_W-1:0]  pulse_reg;

  function automatic logic addr_protected(input logic [1:0] bp, input logic [SFS_ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    case (bp)
      SFS_BP_QUARTER: hit = (a >= SFS_QUARTER_BASE); // RULE_13
      SFS_BP_HALF:    hit = (a >= SFS_HALF_BASE); // RULE_13
      SFS_BP_ALL:     hit = 1'b1; // RULE_13
      default:        hit = 1'b0;
    endcase
    return hit;
  endfunction

  // deselect clears the frame; while hold is low a rising select is ignored
  assign frame_rst_n = arst_n & ~(cs_n & hold_n); // RULE_02 RULE_01 RULE_07
  assign link_go     = hold_n & ~cs_n; // RULE_09 RULE_07 RULE_08

  // everything at the link is edge driven by sck, so no rate floor exists
  assign byte_in   = {shift_reg, si}; // RULE_04
  assign byte_done = (bit_cnt_reg == SFS_BIT_LAST);

  assign status_view = (status_reg & SFS_ST_WR_MASK) | ({7'h00, wel_reg} << SFS_ST_WEL);
  assign array_locked = addr_protected(status_reg[SFS_ST_BP_HI:SFS_ST_BP_LO], addr_reg);
  assign status_locked = status_reg[SFS_ST_LOCK] & ~wp_n; // RULE_06

  // bit counter and input shifter
  always_ff @(posedge sck or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      bit_cnt_reg <= '0;
      shift_reg   <= '0;
    end
    else if (link_go)
    begin
      bit_cnt_reg <= bit_cnt_reg + SFS_BIT_ONE; // RULE_03
      shift_reg   <= byte_in[6:0]; // RULE_03
    end
  end

  // command sequencing: opcode, address, then a data stream
  always_ff @(posedge sck or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      phase_reg   <= SFS_PH_OPCODE; // RULE_02
      op_read_reg <= 1'b0;
      addr_reg    <= '0;
      tx_reg      <= '0;
    end
    else if (link_go && byte_done)
    begin
      case (phase_reg)
        SFS_PH_OPCODE:
        begin
          case (byte_in) // RULE_15
            SFS_OP_READ:
            begin
              op_read_reg <= 1'b1;
              phase_reg   <= SFS_PH_ADDR_HI;
            end
            SFS_OP_WRIT:
            begin
              op_read_reg <= 1'b0;
              phase_reg   <= SFS_PH_ADDR_HI;
            end
            SFS_OP_RDSR:
            begin
              tx_reg    <= status_view;
              phase_reg <= SFS_PH_STAT_RD;
            end
            SFS_OP_WRSR: phase_reg <= SFS_PH_STAT_WR;
            default:     phase_reg <= SFS_PH_IGNORE; // RULE_17
          endcase
        end
        SFS_PH_ADDR_HI:
        begin
          addr_reg[12:8] <= byte_in[4:0]; // RULE_16
          phase_reg      <= SFS_PH_ADDR_LO;
        end
        SFS_PH_ADDR_LO:
        begin
          addr_reg[7:0] <= byte_in; // RULE_16
          if (op_read_reg)
          begin
            tx_reg    <= mem_bus.rd_data;
            phase_reg <= SFS_PH_DATA_RD;
          end
          else
          begin
            phase_reg <= SFS_PH_DATA_WR;
          end
        end
        SFS_PH_DATA_WR:
        begin
          // address wraps at the top of the array
          addr_reg <= addr_reg + SFS_ADDR_ONE;
        end
        SFS_PH_DATA_RD:
        begin
          addr_reg <= addr_reg + SFS_ADDR_ONE;
          tx_reg   <= mem_bus.rd_data;
        end
        SFS_PH_STAT_RD:  tx_reg <= status_view;
        SFS_PH_STAT_WR:  phase_reg <= SFS_PH_IGNORE;
        SFS_PH_IGNORE:   phase_reg <= SFS_PH_IGNORE; // RULE_17
        default:         phase_reg <= SFS_PH_IGNORE;
      endcase
    end
  end

  // array port: write lands on the eighth rising edge of each data byte
  assign mem_bus.wr_en   = link_go & byte_done & (phase_reg == SFS_PH_DATA_WR)
                           & wel_reg & ~array_locked; // RULE_11 RULE_19 RULE_13
  assign mem_bus.wr_addr = addr_reg; // RULE_10
  assign mem_bus.wr_data = byte_in;
  // next read byte is looked up ahead so it is ready at the falling edge
  assign mem_bus.rd_addr = (phase_reg == SFS_PH_ADDR_LO) ? {addr_reg[12:8], byte_in}
                                                         : addr_reg + SFS_ADDR_ONE;

  sfs_mem u_mem
  (
    .clk (sck),
    .mem (mem_bus)
  );

  // output stage on the falling edge; a mode three frame's first fall is harmless
  always_ff @(negedge sck or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      so_reg    <= 1'b0;
      drive_reg <= 1'b0;
    end
    else if (link_go)
    begin
      so_reg    <= tx_reg[~bit_cnt_reg]; // RULE_03 RULE_12
      drive_reg <= (phase_reg == SFS_PH_DATA_RD) || (phase_reg == SFS_PH_STAT_RD); // RULE_05
    end
  end

  assign so    = so_reg;
  assign so_oe = drive_reg & hold_n & ~cs_n; // RULE_05 RULE_01

  // persistent status and latch; a stopped clock would stall a sync reset
  always_ff @(posedge sck or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_reg <= SFS_STATUS_RST;
      wel_reg    <= 1'b0;
    end
    else if (link_go && byte_done)
    begin
      if (phase_reg == SFS_PH_OPCODE && byte_in == SFS_OP_WREN)
      begin
        wel_reg <= 1'b1; // RULE_19
      end
      else if (phase_reg == SFS_PH_OPCODE && byte_in == SFS_OP_WRDI)
      begin
        wel_reg <= 1'b0; // RULE_14
      end
      else if (phase_reg == SFS_PH_STAT_WR && wel_reg && !status_locked)
      begin
        status_reg <= byte_in & SFS_ST_WR_MASK; // RULE_06 RULE_19
      end
    end
  end

  // event toggles toward the system clock: commit, refused write, bad opcode
  always_comb
  begin
    tgl_next = tgl_reg;
    if (mem_bus.wr_en)
    begin
      tgl_next[0] = ~tgl_reg[0];
    end
    if (link_go && byte_done)
    begin
      if ((phase_reg == SFS_PH_DATA_WR && (!wel_reg || array_locked))
          || (phase_reg == SFS_PH_STAT_WR && (!wel_reg || status_locked)))
      begin
        tgl_next[1] = ~tgl_reg[1];
      end
      if (phase_reg == SFS_PH_OPCODE && byte_in != SFS_OP_READ && byte_in != SFS_OP_WRIT
          && byte_in != SFS_OP_RDSR && byte_in != SFS_OP_WRSR
          && byte_in != SFS_OP_WREN && byte_in != SFS_OP_WRDI)
      begin
        tgl_next[2] = ~tgl_reg[2]; // RULE_17
      end
    end
  end

  always_ff @(posedge sck or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tgl_reg <= '0;
    end
    else
    begin
      tgl_reg <= tgl_next;
    end
  end

  // sck level latched at the select fall itself; a later clk_sys look may see it running
  always_ff @(negedge cs_n or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_lnk_reg <= 1'b0;
    end
    else
    begin
      mode_lnk_reg <= sck; // RULE_18
    end
  end

  // system domain: pins and toggles pass two flops first
  assign sync_in = {cs_n, mode_lnk_reg, tgl_reg};

  sfs_sync #(.W(SFS_TGL_W + 2)) u_sync
  (
    .clk    (clk_sys),
    .arst_n (arst_n),
    .d      (sync_in),
    .q      (sync_q)
  );

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cs_prev_reg <= 1'b1;
      standby_reg <= 1'b1;
      mode3_reg   <= 1'b0;
    end
    else
    begin
      cs_prev_reg <= sync_q[SFS_TGL_W+1];
      standby_reg <= sync_q[SFS_TGL_W+1]; // RULE_01
      // mode bit may lag select by a cycle, so take it from the second low sample
      if (!cs_prev_reg && !sync_q[SFS_TGL_W+1])
      begin
        mode3_reg <= sync_q[SFS_TGL_W]; // RULE_18 RULE_12
      end
    end
  end

  // one system cycle pulse per link event; events under two cycles apart may merge or cancel
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tgl_prev_reg <= '0;
      pulse_reg    <= '0;
    end
    else
    begin
      tgl_prev_reg <= sync_q[SFS_TGL_W-1:0];
      pulse_reg    <= sync_q[SFS_TGL_W-1:0] ^ tgl_prev_reg;
    end
  end

  assign standby       = standby_reg;
  assign spi_mode3     = mode3_reg;
  assign byte_commit   = pulse_reg[0];
  assign write_refused = pulse_reg[1];
  assign bad_opcode    = pulse_reg[2];

endmodule

// *** sfs_monitor.sv ***
// sfs_monitor: concurrent checks on the slave's pins
// assumes: bound to sfs_top from tb; sck idles between frames
`timescale 1ns/1ps
module sfs_monitor
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic so,
  input wire logic so_oe,
  input wire logic hold_n,
  input wire logic standby,
  input wire logic spi_mode3,
  input wire logic byte_commit,
  input wire logic write_refused,
  input wire logic bad_opcode
);
  logic so_rise_reg;
  logic mode_reg;

  // so seen at a rise must still stand at the next fall
  always_ff @(posedge sck or negedge arst_n)
  begin
    if (!arst_n)
      so_rise_reg <= 1'b0;
    else
      so_rise_reg <= so;
  end

  always_ff @(negedge cs_n or negedge arst_n)
  begin
    if (!arst_n)
      mode_reg <= 1'b0;
    else
      mode_reg <= sck;
  end

  sequence cs_idle;
    cs_n [*5];
  endsequence

  sequence cs_busy;
    !cs_n [*5];
  endsequence

  oe_deselect_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cs_n |-> !so_oe) else $error("so_oe high while deselected");
  oe_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !hold_n |-> !so_oe) else $error("so_oe high during hold");
  standby_on_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cs_idle |-> standby) else $error("standby low while deselected");
  standby_off_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cs_busy |-> !standby) else $error("standby high while selected");
  so_fall_only_a: assert property (@(negedge sck) disable iff (!arst_n)
    so_oe |-> so == so_rise_reg) else $error("so moved on a rising edge");
  mode_detect_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cs_busy |-> spi_mode3 == mode_reg) else $error("clock mode misread");
  commit_pulse_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    byte_commit |=> !byte_commit) else $error("commit pulse too long");
  refuse_pulse_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    write_refused |=> !write_refused) else $error("refusal pulse too long");
  bad_quiet_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    bad_opcode |=> (!so_oe) [*6]) else $error("output driven after bad opcode");
endmodule

// *** sfs_master.sv ***
// sfs_master: behavioural bus master sending whole frames
// assumes: tb calls frame(); sck stands still outside frames
`timescale 1ns/1ps
module sfs_master
(
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  output logic      hold_n,
  input  wire logic so
);
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end

  task automatic frame(input bit m3, input logic [7:0] tx[$], input int hold_at,
                       output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    sck = m3;
    #5 cs_n = 1'b0;
    #16;
    for (int k = 0; k < tx.size(); k++)
    begin
      if (k == hold_at)
      begin
        sck = 1'b0;
        #8 hold_n = 1'b0;
        // clock edges during hold must be ignored
        repeat (3)
        begin
          #8 sck = 1'b1;
          si = ~si;
          #8 sck = 1'b0;
        end
        #8 hold_n = 1'b1;
      end
      #(16 * $urandom_range(0, 2));
      for (int i = 7; i >= 0; i--)
      begin
        sck = 1'b0;
        si = tx[k][i];
        #16 sck = 1'b1;
        b[i] = so;
        #16;
      end
      rx.push_back(b);
    end
    if (!m3)
      sck = 1'b0;
    #16 cs_n = 1'b1;
    si = ~si;
  endtask
endmodule

// *** tb.sv ***
// tb: self-checking bench for sfs_top with a reference model
// assumes: sfs_master drives the link, tb drives reset and wp_n
`timescale 1ns/1ps
module tb;
  import sfs_pkg::*;
  logic clk_sys, arst_n, sck, cs_n, si, so, so_oe, wp_n, hold_n;
  logic standby, spi_mode3, byte_commit, write_refused, bad_opcode;
  int         n_errors, tests_run, n_com, n_ref, n_bad, e_com, e_ref, e_bad;
  int         n_drv, e_drv;
  logic [7:0] mem_m [int];
  logic [7:0] st_m;
  logic       wel_m;
  logic [12:0] addr_r;

  sfs_top i_sfs_top (.clk_sys(clk_sys), .arst_n(arst_n), .sck(sck), .cs_n(cs_n), .si(si),
    .so(so), .so_oe(so_oe), .wp_n(wp_n), .hold_n(hold_n), .standby(standby),
    .spi_mode3(spi_mode3), .byte_commit(byte_commit), .write_refused(write_refused),
    .bad_opcode(bad_opcode));
  sfs_master i_sfs_master (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so));

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    if (byte_commit === 1'b1) n_com++;
    if (write_refused === 1'b1) n_ref++;
    if (bad_opcode === 1'b1) n_bad++;
  end

  // every sampling edge at which the slave drives its output
  always @(posedge sck)
  begin
    if (so_oe === 1'b1) n_drv++;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  function automatic bit prot(input int a);
    return st_m[3:2] == SFS_BP_ALL || (st_m[3:2] == SFS_BP_HALF && a >= 'h1000) ||
           (st_m[3:2] == SFS_BP_QUARTER && a >= 'h1800);
  endfunction

  task automatic run(input bit m3, input logic [7:0] tx[$]);
    logic [7:0] rx[$];
    int a;
    @(negedge clk_sys);
    i_sfs_master.frame(m3, tx, $urandom_range(0, 5), rx);
    a = (tx.size() > 2) ? {tx[1][4:0], tx[2]} : 0;
    case (tx[0])
      SFS_OP_WREN: wel_m = 1'b1;
      SFS_OP_WRDI: wel_m = 1'b0;
      SFS_OP_RDSR:
      begin
        e_drv += 8 * (tx.size() - 1);
        for (int i = 1; i < rx.size(); i++)
          chk("status", rx[i], {st_m[7], 3'h0, st_m[3:2], wel_m, 1'b0});
      end
      SFS_OP_WRSR:
        if (wel_m && !(st_m[7] && !wp_n)) st_m = tx[1] & SFS_ST_WR_MASK;
        else e_ref++;
      SFS_OP_READ:
      begin
        e_drv += 8 * (tx.size() - 3);
        for (int i = 3; i < rx.size(); i++)
        begin
          if (mem_m.exists(a)) chk("read", rx[i], mem_m[a]);
          a = (a + 1) % SFS_MEM_DEPTH;
        end
      end
      SFS_OP_WRIT:
        for (int i = 3; i < tx.size(); i++)
        begin
          if (wel_m && !prot(a))
          begin
            mem_m[a] = tx[i];
            e_com++;
          end
          else e_ref++;
          a = (a + 1) % SFS_MEM_DEPTH;
        end
      default: e_bad++;
    endcase
    // pulses cross into clk_sys a few cycles late
    repeat (8) @(negedge clk_sys);
    chk("commits", n_com, e_com);
    chk("refusals", n_ref, e_ref);
    chk("bad opcodes", n_bad, e_bad);
    chk("drive bits", n_drv, e_drv);
    chk("mode", spi_mode3, m3);
    chk("standby", standby, 1);
  endtask

  initial
  begin
    void'($urandom(32'hF1215167));
    arst_n = 1'b0;
    wp_n = 1'b1;
    st_m = SFS_STATUS_RST;
    wel_m = 1'b0;
    repeat (6) @(negedge clk_sys);
    arst_n = 1'b1;
    chk("so_oe", so_oe, 0);
    repeat (3) @(negedge clk_sys);
    run(0, '{SFS_OP_WRIT, 8'h00, 8'h10, 8'hA5});
    run(1, '{SFS_OP_WREN});
    for (int r = 0; r < 6; r++)
    begin
      addr_r = (r < 2) ? 13'h1FFE : 13'($urandom);
      run(r[0], '{SFS_OP_WRIT, {3'h7, addr_r[12:8]}, addr_r[7:0], 8'($urandom),
                  8'($urandom), 8'($urandom)});
      run(!r[0], '{SFS_OP_READ, {3'h0, addr_r[12:8]}, addr_r[7:0], 8'h00, 8'h00, 8'h00});
    end
    for (int bp = 1; bp < 4; bp++)
    begin
      run(0, '{SFS_OP_WRSR, 8'(bp << 2)});
      run(0, '{SFS_OP_RDSR, 8'h00});
      for (int h = 0; h < 2; h++)
      begin
        addr_r = h ? 13'h17FF : 13'h0FFF;
        run(1, '{SFS_OP_WRIT, {3'h0, addr_r[12:8]}, 8'hFF, 8'($urandom), 8'($urandom)});
        run(0, '{SFS_OP_READ, {3'h0, addr_r[12:8]}, 8'hFF, 8'h00, 8'h00});
      end
    end
    run(0, '{SFS_OP_WRSR, 8'h80});
    @(negedge clk_sys) wp_n = 1'b0;
    run(1, '{SFS_OP_WRSR, 8'h0C});
    run(0, '{SFS_OP_RDSR, 8'h00});
    @(negedge clk_sys) wp_n = 1'b1;
    run(0, '{SFS_OP_WRSR, 8'h00});
    run(1, '{SFS_OP_WRDI});
    run(0, '{SFS_OP_WRIT, 8'h1F, 8'hFE, 8'h5A});
    run(1, '{SFS_OP_READ, 8'h1F, 8'hFE, 8'h00});
    run(0, '{SFS_OP_RDSR, 8'h00});
    run(0, '{8'hFF, SFS_OP_READ, 8'h00, 8'h00});
    give_verdict;
  end

  initial
  begin
    #1000000;
    n_errors++;
    give_verdict;
  end
endmodule

bind sfs_top sfs_monitor i_sfs_monitor (.clk_sys(clk_sys), .arst_n(arst_n), .sck(sck),
  .cs_n(cs_n), .so(so), .so_oe(so_oe), .hold_n(hold_n), .standby(standby),
  .spi_mode3(spi_mode3), .byte_commit(byte_commit), .write_refused(write_refused),
  .bad_opcode(bad_opcode));
